// ==== logic/sltc_pkg.sv ====
package sltc_pkg;

	// Register addresses on the configuration port.
	localparam logic [7:0] LANE_DRIVER_CONFIG_ADDR = 8'h47;
	localparam logic [7:0] LINK_CONTROL_ONE_ADDR   = 8'h60;

	// Reset values.
	localparam logic [7:0] LANE_DRIVER_CONFIG_RESET = 8'h00;
	localparam logic [7:0] LINK_CONTROL_ONE_RESET   = 8'h7F;

	// Field positions of the lane driver register.
	localparam int SWING_MSB      = 6;
	localparam int SWING_LSB      = 4;
	localparam int DEEMPH_MSB     = 2;
	localparam int DEEMPH_LSB     = 0;
	localparam int DRV_RSVD_HI    = 7;
	localparam int DRV_RSVD_LO    = 3;

	// Field positions of the link control register.
	localparam int SCRAMBLER_BIT  = 7;
	localparam int FRAMES_MSB     = 6;
	localparam int FRAMES_LSB     = 2;
	localparam int LINK_RSVD_BIT  = 1;
	localparam int LINK_ON_BIT    = 0;

	// Legal frame count window and the unlisted de-emphasis code.
	localparam logic [5:0] FRAMES_MIN    = 6'h11;
	localparam logic [5:0] FRAMES_MAX    = 6'h20;
	localparam logic [2:0] DEEMPH_UNUSED = 3'h6;

	// Idle pattern sent on each lane while the link is off.
	localparam logic [7:0] IDLE_PATTERN  = 8'h55;
	localparam int         LANE_COUNT    = 2;

	typedef enum logic [1:0]
	{
		SLTC_IDLE  = 2'b00,
		SLTC_WRITE = 2'b01,
		SLTC_READ  = 2'b10
	} sltc_host_state_type;

endpackage : sltc_pkg

// ==== logic/sltc_if.sv ====
`timescale 1ns/1ns
// Register port between the configuration master and the transmitter config bank.
interface sltc_if;
	logic       wr_en;
	logic       rd_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       rvalid;
	logic       addr_err;

	modport device
	(
		input  wr_en,
		input  rd_en,
		input  addr,
		input  wdata,
		output rdata,
		output rvalid,
		output addr_err
	);

	modport host
	(
		output wr_en,
		output rd_en,
		output addr,
		output wdata,
		input  rdata,
		input  rvalid,
		input  addr_err
	);
endinterface : sltc_if

// ==== logic/sltc_lane_tx.sv ====
`timescale 1ns/1ns
// One serial lane word source: idle pattern while off, user data while on.
module sltc_lane_tx
(
	input  wire logic       MCLK,
	input  wire logic       RESET,
	input  wire logic       link_on,
	input  wire logic [7:0] data_in,
	output logic      [7:0] word_out
);
	import sltc_pkg::*;

	wire logic [7:0] next_word;

	// Off link sends the alternating stream instead of traffic.
	assign next_word = link_on ? data_in : IDLE_PATTERN; // [R12] [R11]

	// Lane word register.
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
			word_out <= IDLE_PATTERN;
		else
			word_out <= next_word;
	end
endmodule : sltc_lane_tx

// ==== logic/sltc_device.sv ====
`timescale 1ns/1ns
// Functional notes
// R1: Software writes zero to driver bit seven.
// R2: Swing code taken from bits six to four.
// R3: Software writes zero to driver bit three.
// R4: De-emphasis code taken from bits two to zero.
// R5: Disable link before changing link control fields.
// R6: Bit seven switches the scrambler, reset off.
// R7: Bits six to two hold frames minus one.
// R8: Software keeps frame count within seventeen to 32.
// R9: Frame count field resets to all ones.
// R10: Software always writes one to bit one.
// R11: Link enabled carries data normally, reset on.
// R12: Disabled link sends alternating idle pattern.
// R13: Drive settings shared by lanes; reads return writes.
module sltc_device
(
	input  wire logic                 MCLK,
	input  wire logic                 RESET,
	sltc_if.device                    BUS,
	input  wire logic [15:0]          LANE_DATA,
	output logic      [15:0]          LANE_WORD,
	output logic      [2:0]           LANE_SWING,
	output logic      [2:0]           LANE_DEEMPH,
	output logic                      SCRAMBLER_ON,
	output logic      [5:0]           FRAME_COUNT,
	output logic                      LINK_ON,
	output logic                      CONFIG_WARN
);
	import sltc_pkg::*;

	// Frame count shown while reset holds, derived from the link register reset image.
	localparam logic [5:0] FRAME_COUNT_RESET = {1'b0, LINK_CONTROL_ONE_RESET[FRAMES_MSB:FRAMES_LSB]} + 6'h01;

	// Stored register images, kept exactly as written.
	logic [7:0] lane_driver_config;
	logic [7:0] link_control_one;

	// Registered read answer towards the master.
	logic [7:0] rdata;
	logic       rvalid;
	logic       addr_err;

	// Registered copies of the derived status outputs.
	logic [5:0] frame_count;
	logic       config_warn;

	// Address decode results.
	wire logic       hit_driver;
	wire logic       hit_link;
	wire logic       hit_any;

	// Write strobes qualified by the decode, and the undecoded access strobe.
	wire logic       write_driver;
	wire logic       write_link;
	wire logic       any_access;

	// Values that the registers take at the next edge.
	wire logic [7:0] next_lane_driver_config;
	wire logic [7:0] next_link_control_one;
	wire logic [7:0] next_rdata;
	wire logic       next_addr_err;
	wire logic [7:0] read_mux;

	// Derived values, worked out from the next register images.
	wire logic [4:0] next_frames_less_one;
	wire logic [5:0] next_frame_count;
	wire logic [2:0] next_deemph;
	wire logic       next_bad_frames;
	wire logic       next_bad_reserved;
	wire logic       next_bad_deemph;
	wire logic       next_config_warn;

	// Address decode for the two registers.
	assign hit_driver = BUS.addr == LANE_DRIVER_CONFIG_ADDR;
	assign hit_link   = BUS.addr == LINK_CONTROL_ONE_ADDR;
	assign hit_any    = hit_driver | hit_link;

	// A write lands only on a mapped address; unmapped writes are dropped.
	assign write_driver = BUS.wr_en & hit_driver;
	assign write_link   = BUS.wr_en & hit_link;
	assign any_access   = BUS.rd_en | BUS.wr_en;

	// Every bit is stored as written, reserved bits included, so a read returns the write.
	assign next_lane_driver_config = write_driver ? BUS.wdata : lane_driver_config; // [R13]
	assign next_link_control_one   = write_link ? BUS.wdata : link_control_one;

	// Reads return whole stored bytes, unmapped addresses read zero.
	assign read_mux = hit_driver ? lane_driver_config : // [R13]
		(hit_link ? link_control_one : 8'h00);

	// Read data changes only on a read, so the last answer stays readable.
	assign next_rdata    = BUS.rd_en ? read_mux : rdata;
	assign next_addr_err = any_access & ~hit_any;

	// Frame count is the stored field plus one; the widened sum cannot wrap.
	assign next_frames_less_one = next_link_control_one[FRAMES_MSB:FRAMES_LSB];
	assign next_frame_count     = {1'b0, next_frames_less_one} + 6'h01; // [R7]
	assign next_deemph          = next_lane_driver_config[DEEMPH_MSB:DEEMPH_LSB];

	// Settings that software was told to avoid are stored anyway, but raise a warning.
	assign next_bad_frames   = next_frame_count < FRAMES_MIN; // [R8]
	assign next_bad_reserved = next_lane_driver_config[DRV_RSVD_HI] | // [R1]
		next_lane_driver_config[DRV_RSVD_LO] | // [R3]
		~next_link_control_one[LINK_RSVD_BIT]; // [R10]
	assign next_bad_deemph   = next_deemph == DEEMPH_UNUSED; // [R4]
	assign next_config_warn  = next_bad_frames | next_bad_reserved | next_bad_deemph;

	// Lane driver register holding the swing and de-emphasis codes.
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
			lane_driver_config <= LANE_DRIVER_CONFIG_RESET;
		else
			lane_driver_config <= next_lane_driver_config; // [R2] [R4]
	end

	// Link control register; reset leaves the link on with the largest frame count.
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
			link_control_one <= LINK_CONTROL_ONE_RESET; // [R9] [R11] [R6]
		else
			link_control_one <= next_link_control_one;
	end

	// Read data register, refreshed by each read.
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
			rdata <= 8'h00;
		else
			rdata <= next_rdata;
	end

	// Read valid pulse, one cycle after the strobe.
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
			rvalid <= 1'b0;
		else
			rvalid <= BUS.rd_en;
	end

	// Unmapped access pulse, one cycle after the strobe.
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
			addr_err <= 1'b0;
		else
			addr_err <= next_addr_err;
	end

	// Frame count output register, updated at the same edge as its field.
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
			frame_count <= FRAME_COUNT_RESET; // [R9]
		else
			frame_count <= next_frame_count; // [R7]
	end

	// Warning register; the reset images are legal settings, so it resets low.
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
			config_warn <= 1'b0;
		else
			config_warn <= next_config_warn;
	end

	// Answer towards the master.
	assign BUS.rdata    = rdata;
	assign BUS.rvalid   = rvalid;
	assign BUS.addr_err = addr_err;

	// Transmitter driver codes come straight from the stored fields.
	assign LANE_SWING   = lane_driver_config[SWING_MSB:SWING_LSB]; // [R2]
	assign LANE_DEEMPH  = lane_driver_config[DEEMPH_MSB:DEEMPH_LSB]; // [R4]

	// Link fields come straight from the stored register.
	assign SCRAMBLER_ON = link_control_one[SCRAMBLER_BIT]; // [R6]
	assign LINK_ON      = link_control_one[LINK_ON_BIT]; // [R11]

	// Derived status outputs from their own flip-flops.
	assign FRAME_COUNT  = frame_count; // [R7]
	assign CONFIG_WARN  = config_warn;

	// Both lanes share one enable and one drive setting.
	genvar lane;
	generate
		for (lane = 0; lane < LANE_COUNT; lane++)
		begin : g_lane
			sltc_lane_tx u_lane
			(
				.MCLK     (MCLK),
				.RESET    (RESET),
				.link_on  (LINK_ON), // [R12] [R13]
				.data_in  (LANE_DATA[lane*8 +: 8]),
				.word_out (LANE_WORD[lane*8 +: 8])
			);
		end
	endgenerate
endmodule : sltc_device

// ==== logic/sltc_host.sv ====
`timescale 1ns/1ns
// Configuration master: turns user requests into single-cycle register strobes.
module sltc_host
(
	input  wire logic       MCLK,
	input  wire logic       RESET,
	sltc_if.host            BUS,
	input  wire logic       REQ_WRITE,
	input  wire logic       REQ_READ,
	input  wire logic [7:0] REQ_ADDR,
	input  wire logic [7:0] REQ_DATA,
	output logic            REQ_READY,
	output logic      [7:0] RSP_DATA,
	output logic            RSP_VALID
);
	import sltc_pkg::*;

	sltc_host_state_type state;
	sltc_host_state_type next_state;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] link_shadow;
	wire logic [7:0] legal_wdata;
	wire logic       link_write;
	wire logic       needs_off;

	// Forces reserved bits to the values software must write.
	assign link_write  = REQ_ADDR == LINK_CONTROL_ONE_ADDR;
	assign legal_wdata = (REQ_ADDR == LANE_DRIVER_CONFIG_ADDR) ?
		(REQ_DATA & ~(8'h88)) : // [R1] [R3]
		(link_write ? (REQ_DATA | 8'h02) : REQ_DATA); // [R10]
	// A config change with the link on turns the link off instead; the change itself is not written.
	assign needs_off = link_write & link_shadow[LINK_ON_BIT] &
		(legal_wdata[7:1] != link_shadow[7:1]); // [R5]

	assign REQ_READY = state == SLTC_IDLE;

	always_comb
	begin
		unique case (state)
			SLTC_IDLE:  next_state = REQ_WRITE ? SLTC_WRITE : (REQ_READ ? SLTC_READ : SLTC_IDLE);
			SLTC_WRITE: next_state = SLTC_IDLE;
			SLTC_READ:  next_state = BUS.rvalid ? SLTC_IDLE : SLTC_READ;
			default:    next_state = SLTC_IDLE;
		endcase
	end

	// Strobe generation and answer capture.
	always_ff @(posedge MCLK or posedge RESET)
	begin
		if (RESET)
		begin
			state       <= SLTC_IDLE;
			addr        <= 8'h00;
			wdata       <= 8'h00;
			link_shadow <= LINK_CONTROL_ONE_RESET;
			RSP_DATA    <= 8'h00;
			RSP_VALID   <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			RSP_VALID <= (state == SLTC_READ) & BUS.rvalid;
			if (state == SLTC_READ && BUS.rvalid)
				RSP_DATA <= BUS.rdata;
			if (REQ_READY && (REQ_WRITE || REQ_READ))
			begin
				addr  <= REQ_ADDR;
				wdata <= needs_off ? (link_shadow & 8'hFE) : legal_wdata;
				if (REQ_WRITE && link_write)
					link_shadow <= needs_off ? (link_shadow & 8'hFE) : legal_wdata; // [R5]
			end
		end
	end

	assign BUS.wr_en = state == SLTC_WRITE;
	assign BUS.rd_en = (state == SLTC_READ) & ~BUS.rvalid;
	assign BUS.addr  = addr;
	assign BUS.wdata = wdata;
endmodule : sltc_host

// ==== bench/sltc_chk.sv ====
`timescale 1ns/1ns
// Watches the register port and the lane outputs of the config bank.
module sltc_chk
	import sltc_pkg::*;
(
	input wire logic        MCLK,
	input wire logic        RESET,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [7:0]  addr,
	input wire logic [7:0]  wdata,
	input wire logic        rvalid,
	input wire logic        addr_err,
	input wire logic [15:0] LANE_DATA,
	input wire logic [15:0] LANE_WORD,
	input wire logic [2:0]  LANE_SWING,
	input wire logic [2:0]  LANE_DEEMPH,
	input wire logic        SCRAMBLER_ON,
	input wire logic [5:0]  FRAME_COUNT,
	input wire logic        LINK_ON
);
	// Decodes of the two mapped registers.
	wire hit_drv = addr == LANE_DRIVER_CONFIG_ADDR;
	wire hit_lnk = addr == LINK_CONTROL_ONE_ADDR;
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);
	sequence s_drv_wr; wr_en && hit_drv; endsequence
	sequence s_lnk_wr; wr_en && hit_lnk; endsequence
	chk_swing_write: assert property (s_drv_wr |=> LANE_SWING == $past(wdata[6:4]))
		else $error("swing code not taken");
	chk_deemph_write: assert property (s_drv_wr |=> LANE_DEEMPH == $past(wdata[2:0]))
		else $error("de-emphasis code not taken");
	chk_scrambler_write: assert property (s_lnk_wr |=> SCRAMBLER_ON == $past(wdata[7]))
		else $error("scrambler bit not taken");
	chk_frame_write: assert property (s_lnk_wr |=> FRAME_COUNT == {1'b0, $past(wdata[6:2])} + 6'h01)
		else $error("frame count is not field plus one");
	chk_link_write: assert property (s_lnk_wr |=> LINK_ON == $past(wdata[0]))
		else $error("link enable not taken");
	chk_idle_word: assert property (!LINK_ON |=> LANE_WORD == 16'h5555)
		else $error("idle pattern missing");
	chk_data_word: assert property (LINK_ON |=> LANE_WORD == $past(LANE_DATA))
		else $error("lane data not passed");
	chk_read_answer: assert property ($rose(rd_en) && (hit_drv || hit_lnk) |=> rvalid)
		else $error("read answer late");
	chk_unmapped_flag: assert property ((wr_en || $rose(rd_en)) && !(hit_drv || hit_lnk) |=> addr_err)
		else $error("unmapped access not flagged");
endmodule : sltc_chk

// ==== bench/tb_serial_link_tx_config_regs.sv ====
`timescale 1ns/1ns
// Drives the config master with register traffic and checks the bank outputs.
module tb_serial_link_tx_config_regs;
	import sltc_pkg::*;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("Error %0t: got %h want %h", $time, g, e); end end
	logic        MCLK = 1'b0;
	logic        RESET = 1'b1;
	logic        rq_w = 1'b0;
	logic        rq_r = 1'b0;
	logic [7:0]  rq_a = 8'h00;
	logic [7:0]  rq_d = 8'h00;
	logic [15:0] ldat = 16'h0000;
	logic        rdy, rsp_v, scr_on, lon;
	logic [7:0]  rsp_d, rd_val;
	logic [15:0] lword;
	logic [2:0]  sw, de, lsw, lde;
	logic [5:0]  fcnt;
	logic        scr;
	logic        cwarn;
	int          errors = 0;
	int          n_tests = 0;
	int          seed = 52935;
	int          k;
	sltc_if bus ();
	sltc_host sltc_host_inst (.MCLK(MCLK), .RESET(RESET), .BUS(bus.host), .REQ_WRITE(rq_w), .REQ_READ(rq_r),
		.REQ_ADDR(rq_a), .REQ_DATA(rq_d), .REQ_READY(rdy), .RSP_DATA(rsp_d), .RSP_VALID(rsp_v));
	sltc_device sltc_device_inst (.MCLK(MCLK), .RESET(RESET), .BUS(bus.device), .LANE_DATA(ldat), .LANE_WORD(lword),
		.LANE_SWING(lsw), .LANE_DEEMPH(lde), .SCRAMBLER_ON(scr_on), .FRAME_COUNT(fcnt), .LINK_ON(lon),
		.CONFIG_WARN(cwarn));
	sltc_chk sltc_chk_inst (.MCLK(MCLK), .RESET(RESET), .wr_en(bus.wr_en), .rd_en(bus.rd_en), .addr(bus.addr),
		.wdata(bus.wdata), .rvalid(bus.rvalid), .addr_err(bus.addr_err), .LANE_DATA(ldat), .LANE_WORD(lword),
		.LANE_SWING(lsw), .LANE_DEEMPH(lde), .SCRAMBLER_ON(scr_on), .FRAME_COUNT(fcnt), .LINK_ON(lon));
	// The 10 MHz clock.
	always #50 MCLK = ~MCLK;
	// Expected register images.
	function automatic logic [7:0] drv_val(input logic [2:0] s, input logic [2:0] d);
		return {1'b0, s, 1'b0, d};
	endfunction : drv_val
	function automatic logic [7:0] lnk_val(input logic sc, input int kk, input logic on);
		return {sc, 5'(kk - 1), 1'b1, on};
	endfunction : lnk_val
	// One request through the master; a read leaves its answer in rd_val.
	task automatic req(input logic wr, input logic [7:0] a, input logic [7:0] d);
		repeat (20) if (rdy !== 1'b1) @(negedge MCLK);
		if (rdy !== 1'b1)
		begin
			errors++;
			$display("Error %0t: request port never ready", $time);
		end
		rq_w = wr;
		rq_r = !wr;
		rq_a = a;
		rq_d = d;
		@(negedge MCLK);
		rq_w = 1'b0;
		rq_r = 1'b0;
		repeat (8) if (rsp_v !== 1'b1 && !wr) @(negedge MCLK);
		if (!wr && rsp_v !== 1'b1)
		begin
			errors++;
			$display("Error %0t: read answer missing", $time);
		end
		rd_val = rsp_d;
		@(negedge MCLK);
	endtask : req
	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// Cuts a hang short.
	initial
	begin
		#(3000 * 100);
		errors++;
		complete_run();
	end
	// Main sequence.
	initial
	begin
		repeat (12) @(negedge MCLK);
		RESET = 1'b0;
		req(1'b0, LANE_DRIVER_CONFIG_ADDR, 8'h00);
		`CHK(rd_val, drv_val(3'h0, 3'h0))
		req(1'b0, LINK_CONTROL_ONE_ADDR, 8'h00);
		`CHK(rd_val, lnk_val(1'b0, 32, 1'b1))
		`CHK(fcnt, 6'h20)
		`CHK(cwarn, 1'b0)
		$display("reset values done");
		ldat = 16'($random(seed));
		req(1'b1, LINK_CONTROL_ONE_ADDR, lnk_val(1'b0, 32, 1'b0));
		repeat (2) @(negedge MCLK);
		`CHK(lword, 16'h5555)
		for (int i = 0; i < 24; i++)
		begin
			k = (i == 0) ? 17 : (i == 1) ? 32 : 17 + ($unsigned($random(seed)) % 16);
			scr = 1'($random(seed));
			sw = (i < 8) ? 3'(i) : 3'($random(seed));
			de = (i < 8) ? 3'(7 - i) : 3'($random(seed));
			req(1'b1, LANE_DRIVER_CONFIG_ADDR, drv_val(sw, de));
			req(1'b0, LANE_DRIVER_CONFIG_ADDR, 8'h00);
			`CHK(rd_val, drv_val(sw, de))
			`CHK({lsw, lde}, {sw, de})
			`CHK(cwarn, de == DEEMPH_UNUSED)
			req(1'b1, LINK_CONTROL_ONE_ADDR, lnk_val(scr, k, 1'b0));
			req(1'b0, LINK_CONTROL_ONE_ADDR, 8'h00);
			`CHK(rd_val, lnk_val(scr, k, 1'b0))
			`CHK({scr_on, fcnt}, {scr, 6'(k)})
		end
		$display("field sweep done");
		req(1'b1, LINK_CONTROL_ONE_ADDR, lnk_val(scr, 16, 1'b0));
		`CHK({cwarn, fcnt}, {1'b1, 6'h10})
		req(1'b1, LINK_CONTROL_ONE_ADDR, lnk_val(scr, k, 1'b1));
		ldat = 16'($random(seed));
		repeat (2) @(negedge MCLK);
		`CHK(lword, ldat)
		req(1'b1, LINK_CONTROL_ONE_ADDR, lnk_val(!scr, k, 1'b1));
		req(1'b0, LINK_CONTROL_ONE_ADDR, 8'h00);
		`CHK(rd_val, lnk_val(scr, k, 1'b0))
		req(1'b0, 8'h48, 8'h00);
		`CHK(rd_val, 8'h00)
		$display("link and unmapped done");
		complete_run();
	end
endmodule : tb_serial_link_tx_config_regs
